// [pkg/cts_defs.vh]
// Constants for the current transformer supervision block.
// Assumes it is included by bare name from design files.
`ifndef CTS_DEFS_VH
`define CTS_DEFS_VH
`define CTS_CUR_W 16
`define CTS_PCT_W 14
`define CTS_PCT_FULL 14'h2710
`define CTS_HIST_DEPTH 12
`define CTS_CNT_W 16
`define CTS_TS_W 48
`define CTS_DELAY_W 24
`define CTS_EV_ALARM_ON 2'h0
`define CTS_EV_ALARM_OFF 2'h1
`define CTS_EV_BLOCK_ON 2'h2
`define CTS_EV_BLOCK_OFF 2'h3
`define CTS_SEL_ON 2'h1
`define CTS_SEL_OFF 2'h2
`define CTS_FT_OK 4'h0
`define CTS_FT_HIGH 4'h1
`define CTS_FT_LOW 4'h2
`define CTS_FT_RATIO 4'h4
`define CTS_FT_RES 4'h8
`endif

// [design/cts_history.v]
// History store of the last twelve supervision records.
// Assumes records arrive as one-cycle write pulses on mclk.
`timescale 1ns/1ps
`include "cts_defs.vh"
module cts_history #(
   parameter DEPTH = `CTS_HIST_DEPTH,
   parameter REC_W = 64,
   parameter IDX_W = 4
) (
   input wire mclk,
   input wire reset_n,
   input wire wr_en,
   input wire [REC_W-1:0] wr_rec,
   input wire [IDX_W-1:0] rd_idx,
   output reg [REC_W-1:0] rd_rec,
   output reg [IDX_W-1:0] count_q
);
   reg [REC_W-1:0] mem [0:DEPTH-1];
   reg [IDX_W-1:0] wr_ptr_q;
   wire [IDX_W-1:0] last_idx = DEPTH[IDX_W-1:0] - 1'b1;

   // Ring write pointer; the oldest record is overwritten once full.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_q <= {IDX_W{1'b0}};
         count_q <= {IDX_W{1'b0}};
      end else if (wr_en) begin
         wr_ptr_q <= (wr_ptr_q == last_idx) ? {IDX_W{1'b0}} : wr_ptr_q + 1'b1;
         if (count_q != DEPTH[IDX_W-1:0])
            count_q <= count_q + 1'b1;
      end
   end

   // Storage array, no reset needed.
   always @(posedge mclk) begin
      if (wr_en)
         mem[wr_ptr_q] <= wr_rec;
   end

   // Read by age: index 0 is the newest record.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         rd_rec <= {REC_W{1'b0}};
      else if (rd_idx < DEPTH[IDX_W-1:0])
         rd_rec <= mem[(wr_ptr_q > rd_idx) ? wr_ptr_q - rd_idx - 1'b1 :
                       wr_ptr_q + last_idx - rd_idx];
      else
         rd_rec <= {REC_W{1'b0}};
   end
endmodule

// [design/ct_supervision.v]
// Current transformer supervision: limit checks, delay timer, events, counter, history.
// Assumes magnitudes are scaled and stable per program cycle, strobed by cycle_start.
//
// Overview of operation
// - Timer starts when fault conditions all hold; alarm after the full delay.
// - Any phase above the upper limit suppresses activation.
// - All phases below the lower limit suppress activation.
// - Residual selection adds a summed-versus-measured residual comparison.
// - Residual difference below its limit withholds activation.
// - Alarm and block on/off events, each gated by a per-event selection.
// - Every event carries the time stamp of its status change.
// - Cumulative alarm and blocked counter, resettable by software.
// - Twelve record history written on timer start and on on-events, oldest overwritten.
// - Records hold time, event, currents, remaining time, fault code, group.
// - Min over max phase ratio must fall below the ratio limit.
// - Negative over positive sequence ratio must meet its limit.
// - Block sampled per cycle; block at pick-up gives blocked, no timer.
`timescale 1ns/1ps
`include "cts_defs.vh"
module ct_supervision #(
   parameter CW = `CTS_CUR_W,
   parameter PW = `CTS_PCT_W,
   parameter DW = `CTS_DELAY_W,
   parameter NW = `CTS_CNT_W,
   parameter TW = `CTS_TS_W
) (
   input wire mclk,
   input wire reset_n,
   input wire cycle_start,
   input wire [CW-1:0] phase_l1,
   input wire [CW-1:0] phase_l2,
   input wire [CW-1:0] phase_l3,
   input wire [CW-1:0] residual_input_one,
   input wire [CW-1:0] residual_input_two,
   input wire [CW-1:0] residual_sum,
   input wire [CW-1:0] positive_sequence_current,
   input wire [CW-1:0] negative_sequence_current,
   input wire block_pin,
   input wire [CW-1:0] high_limit,
   input wire [CW-1:0] low_limit,
   input wire [PW-1:0] min_max_ratio_limit,
   input wire [PW-1:0] sequence_ratio_limit,
   input wire [CW-1:0] residual_diff_limit,
   input wire [1:0] residual_select,
   input wire [DW-1:0] alarm_delay_cycles,
   input wire [2:0] setting_group,
   input wire [TW-1:0] timestamp,
   input wire [7:0] event_select,
   input wire counter_clear,
   input wire [3:0] hist_rd_idx,
   output wire alarm_activation,
   output wire blocked,
   output wire started,
   output reg event_valid,
   output reg [1:0] event_code,
   output reg [TW-1:0] event_time,
   output reg [NW-1:0] alarm_count_q,
   output reg [NW-1:0] block_count_q,
   output reg [3:0] fault_type_q,
   output wire [TW+2+7*CW+DW+4+3-1:0] hist_rec,
   output wire [3:0] hist_count
);
   localparam REC_W = TW + 2 + 7 * CW + DW + 4 + 3;
   localparam ST_IDLE = 4'h1;
   localparam ST_TIMING = 4'h2;
   localparam ST_ALARM = 4'h4;
   localparam ST_BLOCK = 4'h8;

   // Percent of ratio, scaled so 10000 is 100.00 percent.
   function ratio_ok;
      input [CW-1:0] num;
      input [CW-1:0] den;
      input [PW-1:0] lim;
      reg [CW+PW-1:0] lhs;
      reg [CW+PW-1:0] rhs;
      begin
         lhs = num * `CTS_PCT_FULL;
         rhs = den * lim;
         ratio_ok = lhs >= rhs;
      end
   endfunction

   // Absolute difference of two magnitudes.
   function [CW-1:0] absdiff;
      input [CW-1:0] a;
      input [CW-1:0] b;
      begin
         absdiff = (a > b) ? a - b : b - a;
      end
   endfunction

   // Block pin is asynchronous, so two flip-flops before use.
   reg blk_s1_q;
   reg blk_s2_q;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         blk_s1_q <= 1'b0;
         blk_s2_q <= 1'b0;
      end else begin
         blk_s1_q <= block_pin;
         blk_s2_q <= blk_s1_q;
      end
   end

   // Phase extremes.
   wire [CW-1:0] max12 = (phase_l1 > phase_l2) ? phase_l1 : phase_l2;
   wire [CW-1:0] min12 = (phase_l1 < phase_l2) ? phase_l1 : phase_l2;
   wire [CW-1:0] i_max = (max12 > phase_l3) ? max12 : phase_l3;
   wire [CW-1:0] i_min = (min12 < phase_l3) ? min12 : phase_l3;
   wire [CW-1:0] res_meas = (residual_select == 2'h2) ? residual_input_two : residual_input_one;

   // Activation conditions.
   wire below_high = (i_max <= high_limit);
   wire above_low = (i_max >= low_limit);
   wire minmax_ok = !ratio_ok(i_min, i_max, min_max_ratio_limit);
   wire seq_ok = ratio_ok(negative_sequence_current, positive_sequence_current,
                          sequence_ratio_limit);
   wire res_used = (residual_select != 2'h0);
   wire res_ok = !res_used || (absdiff(residual_sum, res_meas) >= residual_diff_limit);
   wire pickup = below_high && above_low && minmax_ok && seq_ok && res_ok;

   // Fault type code reflects which checks failed.
   reg [3:0] ft_d;
   always @* begin
      ft_d = `CTS_FT_OK;
      if (!below_high)
         ft_d = ft_d | `CTS_FT_HIGH;
      if (!above_low)
         ft_d = ft_d | `CTS_FT_LOW;
      if (!(minmax_ok && seq_ok))
         ft_d = ft_d | `CTS_FT_RATIO;
      if (!res_ok)
         ft_d = ft_d | `CTS_FT_RES;
   end

   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [DW-1:0] timer_q;
   reg [DW-1:0] timer_d;

   // Supervision state machine, evaluated once per program cycle.
   always @* begin
      state_d = state_q;
      timer_d = timer_q;
      if (cycle_start) begin
         case (state_q)
            ST_IDLE: begin
               if (pickup && blk_s2_q)
                  state_d = ST_BLOCK;
               else if (pickup) begin
                  state_d = ST_TIMING;
                  timer_d = alarm_delay_cycles;
               end
            end
            ST_TIMING: begin
               if (!pickup)
                  state_d = ST_IDLE;
               else if (blk_s2_q)
                  state_d = ST_BLOCK;
               else if (timer_q <= {{(DW-1){1'b0}}, 1'b1})
                  state_d = ST_ALARM;
               else
                  timer_d = timer_q - 1'b1;
            end
            ST_ALARM: begin
               if (!pickup || blk_s2_q)
                  state_d = ST_IDLE;
            end
            ST_BLOCK: begin
               if (!pickup || !blk_s2_q)
                  state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
         endcase
         if (state_d != ST_TIMING)
            timer_d = {DW{1'b0}};
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         timer_q <= {DW{1'b0}};
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
      end
   end

   assign alarm_activation = (state_q == ST_ALARM);
   assign blocked = (state_q == ST_BLOCK);
   assign started = (state_q == ST_TIMING);

   // Event detection from state change.
   wire alarm_on = (state_d == ST_ALARM) && (state_q != ST_ALARM);
   wire alarm_off = (state_q == ST_ALARM) && (state_d != ST_ALARM);
   wire block_on = (state_d == ST_BLOCK) && (state_q != ST_BLOCK);
   wire block_off = (state_q == ST_BLOCK) && (state_d != ST_BLOCK);
   wire alarm_sel_on = event_select[0];
   wire alarm_sel_off = event_select[1];
   wire block_sel_on = event_select[2];
   wire block_sel_off = event_select[3];

   // Selected events reach the event buffer port with their time stamp.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         event_valid <= 1'b0;
         event_code <= `CTS_EV_ALARM_ON;
         event_time <= {TW{1'b0}};
      end else begin
         event_valid <= 1'b0;
         event_time <= timestamp;
         if (alarm_on && alarm_sel_on) begin
            event_valid <= 1'b1;
            event_code <= `CTS_EV_ALARM_ON;
         end else if (alarm_off && alarm_sel_off) begin
            event_valid <= 1'b1;
            event_code <= `CTS_EV_ALARM_OFF;
         end else if (block_on && block_sel_on) begin
            event_valid <= 1'b1;
            event_code <= `CTS_EV_BLOCK_ON;
         end else if (block_off && block_sel_off) begin
            event_valid <= 1'b1;
            event_code <= `CTS_EV_BLOCK_OFF;
         end
      end
   end

   // Cumulative counters; a new event in the clear cycle still counts.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         alarm_count_q <= {NW{1'b0}};
         block_count_q <= {NW{1'b0}};
         fault_type_q <= `CTS_FT_OK;
      end else begin
         if (counter_clear)
            alarm_count_q <= alarm_on ? {{(NW-1){1'b0}}, 1'b1} : {NW{1'b0}};
         else if (alarm_on)
            alarm_count_q <= alarm_count_q + 1'b1;
         if (counter_clear)
            block_count_q <= block_on ? {{(NW-1){1'b0}}, 1'b1} : {NW{1'b0}};
         else if (block_on)
            block_count_q <= block_count_q + 1'b1;
         if (cycle_start)
            fault_type_q <= ft_d;
      end
   end

   // History record on timer start and on-events: time, event, currents, time left, fault, group.
   wire rec_wr = alarm_on || block_on || ((state_d == ST_TIMING) && (state_q == ST_IDLE));
   wire [1:0] rec_ev = block_on ? `CTS_EV_BLOCK_ON : `CTS_EV_ALARM_ON;
   wire [REC_W-1:0] rec = {timestamp, rec_ev, phase_l1, phase_l2, phase_l3,
                           residual_input_one, residual_input_two,
                           positive_sequence_current, negative_sequence_current,
                           timer_d, ft_d, setting_group};

   cts_history #(
      .DEPTH(`CTS_HIST_DEPTH),
      .REC_W(REC_W),
      .IDX_W(4)
   ) u_hist (
      .mclk(mclk),
      .reset_n(reset_n),
      .wr_en(rec_wr),
      .wr_rec(rec),
      .rd_idx(hist_rd_idx),
      .rd_rec(hist_rec),
      .count_q(hist_count)
   );
endmodule

// [bench/cur_front_end.sv]
// Model of the current measurement front end feeding the supervision block.
// Assumes a mode code from the bench picks one of a few fixed current pictures.
`timescale 1ns/1ps
module cur_front_end (
   input wire mclk,
   input wire reset_n,
   input wire [2:0] mode,
   output reg cycle_start,
   output reg [15:0] l1, l2, l3, r1, r2, rsum, pos, neg
);
   reg [1:0] cnt_q;
   // A program cycle strobe every fourth clock, launched just after the edge.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 2'h0;
         cycle_start <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         cycle_start <= #1 (cnt_q == 2'h3);
      end
   end
   // Current pictures: healthy, broken L1, overcurrent, low load, earth fault.
   always @* begin
      case (mode)
         3'h1: {l1, l2, l3, pos, neg, rsum, r1} = {16'h0, 16'h3E8, 16'h3E8, 16'h29E, 16'h14A,
                                                   16'h3E8, 16'h0};
         3'h2: {l1, l2, l3, pos, neg, rsum, r1} = {16'h0, 16'h5DC, 16'h5DC, 16'h3E8, 16'h1F4,
                                                   16'h0, 16'h0};
         3'h3: {l1, l2, l3, pos, neg, rsum, r1} = {16'h5, 16'h5A, 16'h5A, 16'h28, 16'h1E,
                                                   16'h0, 16'h0};
         3'h4: {l1, l2, l3, pos, neg, rsum, r1} = {16'h0, 16'h3E8, 16'h3E8, 16'h23A, 16'h140,
                                                   16'h1F4, 16'h1F4};
         default: {l1, l2, l3, pos, neg, rsum, r1} = {16'h3E8, 16'h3E8, 16'h3E8, 16'h3E8,
                                                      16'h0, 16'h0, 16'h0};
      endcase
      r2 = r1;
   end
endmodule

// [bench/ct_supervision_sva.sv]
// Checker for the supervision block, watching only its ports.
// Assumes the header constants for widths and event codes.
`timescale 1ns/1ps
`include "cts_defs.vh"
module ct_supervision_chk (
   input wire mclk,
   input wire reset_n,
   input wire cycle_start,
   input wire [15:0] phase_l1, phase_l2, phase_l3, high_limit, low_limit,
   input wire [15:0] residual_input_one, residual_input_two, residual_sum, residual_diff_limit,
   input wire [1:0] residual_select,
   input wire [47:0] timestamp, event_time,
   input wire [7:0] event_select,
   input wire counter_clear, alarm_activation, started, event_valid,
   input wire [1:0] event_code,
   input wire [15:0] alarm_count_q,
   input wire [3:0] hist_count
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Residual difference as the block should see it.
   wire [15:0] meas = (residual_select == 2'h2) ? residual_input_two : residual_input_one;
   wire [15:0] rdiff = (residual_sum > meas) ? residual_sum - meas : meas - residual_sum;
   wire hi = (phase_l1 > high_limit) || (phase_l2 > high_limit) || (phase_l3 > high_limit);
   wire lo = (phase_l1 < low_limit) && (phase_l2 < low_limit) && (phase_l3 < low_limit);
   sequence drop_s;
      alarm_activation && cycle_start && hi;
   endsequence
   sequence off_ev_s;
      !alarm_activation ##0 (!event_select[1] || (event_valid && event_code == `CTS_EV_ALARM_OFF));
   endsequence
   high_sup_a: assert property (cycle_start && hi |=> !started && !alarm_activation)
      else $error("start seen with phase above upper limit");
   low_sup_a: assert property (cycle_start && lo |=> !started)
      else $error("start seen with all phases below lower limit");
   res_sup_a: assert property (cycle_start && residual_select != 2'h0 && rdiff < residual_diff_limit |=> !started)
      else $error("start seen with small residual difference");
   alarm_off_a: assert property (drop_s |=> off_ev_s)
      else $error("alarm not cleared with its off event");
   alarm_ev_a: assert property ($rose(alarm_activation) && event_select[0] |-> event_valid && event_code == `CTS_EV_ALARM_ON)
      else $error("alarm on event missing");
   ev_time_a: assert property (event_valid |-> event_time <= timestamp && event_time != 48'h0)
      else $error("event time not taken from the time stamp");
   idle_hold_a: assert property (!$past(cycle_start) |-> $stable(started) && $stable(alarm_activation))
      else $error("status changed between program cycles");
   cnt_step_a: assert property ($rose(alarm_activation) && !counter_clear |=> alarm_count_q != 16'h0)
      else $error("alarm counter did not count");
   hist_sat_a: assert property (hist_count <= 4'hC)
      else $error("history count above twelve");
endmodule
bind ct_supervision ct_supervision_chk chk_u (.*);

// [bench/tb_ct_supervision.sv]
// Self-checking bench for the supervision block with a front end model.
// Assumes the header constants; alarm delay set to three program cycles.
`timescale 1ns/1ps
`include "cts_defs.vh"
module tb_ct_supervision;
   reg mclk = 1'b0, reset_n = 1'b0, block_pin = 1'b0, counter_clear = 1'b0;
   reg [2:0] mode = 3'h0;
   reg [1:0] res_sel = 2'h0;
   reg [7:0] ev_sel = 8'h0F;
   reg [47:0] ts = 48'h1;
   reg [23:0] delay = 24'h3;
   reg [2:0] grp = 3'h1;
   reg [3:0] rd_idx = 4'h0;
   wire [192:0] hrec;
   wire [3:0] ftype;
   integer err_count = 0, tests_run = 0, cyc = 0;
   integer ev_n [0:3];
   wire cs, alarm, blocked, started, ev_valid;
   wire [15:0] l1, l2, l3, r1, r2, rsum, pos, neg, acnt, bcnt;
   wire [1:0] ev_code;
   wire [3:0] hcnt;
   cur_front_end fe_u (.mclk(mclk), .reset_n(reset_n), .mode(mode), .cycle_start(cs), .l1(l1),
      .l2(l2), .l3(l3), .r1(r1), .r2(r2), .rsum(rsum), .pos(pos), .neg(neg));
   ct_supervision dut_u (.mclk(mclk), .reset_n(reset_n), .cycle_start(cs), .phase_l1(l1),
      .phase_l2(l2), .phase_l3(l3), .residual_input_one(r1), .residual_input_two(r2),
      .residual_sum(rsum), .positive_sequence_current(pos), .negative_sequence_current(neg),
      .block_pin(block_pin), .high_limit(16'h4B0), .low_limit(16'h64),
      .min_max_ratio_limit(14'h3E8), .sequence_ratio_limit(14'h1324),
      .residual_diff_limit(16'h64), .residual_select(res_sel), .alarm_delay_cycles(delay),
      .setting_group(grp), .timestamp(ts), .event_select(ev_sel),
      .counter_clear(counter_clear), .hist_rd_idx(rd_idx), .alarm_activation(alarm),
      .blocked(blocked), .started(started), .event_valid(ev_valid), .event_code(ev_code),
      .event_time(), .alarm_count_q(acnt), .block_count_q(bcnt), .fault_type_q(ftype),
      .hist_rec(hrec), .hist_count(hcnt));
   // Clock, and reset held for three cycles.
   initial forever #20 mclk = ~mclk;
   initial begin
      ev_n[0] = 0; ev_n[1] = 0; ev_n[2] = 0; ev_n[3] = 0;
      repeat (3) @(posedge mclk);
      #1 reset_n = 1'b1;
      t_alarm; t_high; t_low; t_res; t_block; t_clear;
      stop_test;
   end
   // Time stamp, event tally and a cycle ceiling that cuts a hang short.
   always @(posedge mclk) begin
      if (ev_valid === 1'b1) ev_n[ev_code] = ev_n[ev_code] + 1;
      ts <= #1 ts + 48'h1;
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_count = err_count + 1;
         stop_test;
      end
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
         end
      end
   endtask
   // Waits past n program cycle strobes, then one more clock for the answer.
   task wait_cs(input integer n);
      begin
         repeat (n) begin
            @(posedge mclk);
            while (cs !== 1'b1) @(posedge mclk);
         end
         @(posedge mclk);
         #1;
      end
   endtask
   // Broken phase: start, alarm after the full delay, then clearing.
   task t_alarm;
      begin
         mode = 3'h1; wait_cs(1);
         check(started, 1); check(alarm, 0);
         wait_cs(2); check(alarm, 0);
         wait_cs(1); check(alarm, 1); check(ev_n[0], 1);
         check(acnt, 1); check(hcnt, 2);
         check(hrec[2:0], 3'h1); check(hrec[144:143], `CTS_EV_ALARM_ON);
         mode = 3'h0; wait_cs(1);
         check(alarm, 0); check(started, 0); check(ev_n[1], 1);
      end
   endtask
   task t_high;
      begin
         mode = 3'h2; wait_cs(2); check(started, 0);
         check(ftype, `CTS_FT_HIGH);
         mode = 3'h0;
      end
   endtask
   task t_low;
      begin
         mode = 3'h3; wait_cs(2); check(started, 0);
         mode = 3'h0;
      end
   endtask
   // Residual check: equal sums withhold, a large difference allows start.
   task t_res;
      begin
         res_sel = 2'h1; mode = 3'h4; wait_cs(2); check(started, 0);
         mode = 3'h1; wait_cs(1); check(started, 1);
         mode = 3'h0; wait_cs(1); res_sel = 2'h0;
      end
   endtask
   // Block at pick-up, with the block on event deselected.
   task t_block;
      begin
         ev_sel = 8'h0B; block_pin = 1'b1; wait_cs(2);
         mode = 3'h1; wait_cs(1);
         check(blocked, 1); check(started, 0);
         check(ev_n[2], 0); check(bcnt, 1);
         check(hrec[144:143], `CTS_EV_BLOCK_ON);
         mode = 3'h0; block_pin = 1'b0; wait_cs(2);
         check(blocked, 0); check(ev_n[3] != 0, 1);
         ev_sel = 8'h0F;
      end
   endtask
   task t_clear;
      begin
         counter_clear = 1'b1; wait_cs(1); counter_clear = 1'b0;
         check(acnt, 0); check(bcnt, 0);
      end
   endtask
   task stop_test;
      begin
         $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
         if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
endmodule
